// >>> verilog/adcca_pkg.sv
package adcca_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_CFG_ADDR = 8'hba;
   localparam logic [7:0] CONV_CFG_ADDR = 8'hbc;
   localparam logic [7:0] RESULT_LOW_ADDR = 8'hbe;
   localparam logic [7:0] RESULT_HIGH_ADDR = 8'hbf;

   // ----------------------------------------------------------------
   // Reset values and field codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CONV_CFG_RESET = 8'hf8;
   localparam logic [7:0] ACC_CFG_RESET = 8'h00;
   localparam logic [2:0] SJ_LEFT = 3'h4;
   localparam int unsigned LEFT_SHIFT = 6;

   // ----------------------------------------------------------------
   // Timing in conversion clock cycles
   // ----------------------------------------------------------------
   localparam logic [3:0] BITS_TEN = 4'ha;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [1:0] DELAYED_TRACK_CYCLES = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] sarClockDivider;
      logic eightBitModeEnable;
      logic delayedTrackSelect;
      logic inputGainSelect;
   } adcca_conv_cfg_t;

   typedef struct packed {
      logic accumulateEnable;
      logic [2:0] shiftJustifySelect;
      logic [2:0] repeatCount;
   } adcca_acc_cfg_t;

   typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONVERT} adcca_state_t;

endpackage

// >>> verilog/adcca_config_accumulator.sv
`timescale 1ns/100ps
module adcca_config_accumulator
   import adcca_pkg::*;
#(
   parameter int unsigned RES_WIDTH = 10,
   parameter int unsigned ACC_WIDTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic sfrRdEn,
   input wire logic [7:0] sfrWrData,
   output logic [7:0] sfrRdData,
   // Control from the converter control register, plus the oscillator tick
   input wire logic converterEnable,
   input wire logic burstModeEnable,
   input wire logic startConversion,
   input wire logic lpOscTick,
   // Analog front end
   input wire logic [RES_WIDTH-1:0] sampleCode,
   output logic conversionClock,
   output logic trackActive,
   output logic converting,
   output logic inputGainUnity,
   // Completion
   output logic conversionDone,
   output logic windowCompareGo
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   adcca_conv_cfg_t convCfg_ff, nxt_convCfg;
   adcca_acc_cfg_t accCfg_ff, nxt_accCfg;
   adcca_state_t state_ff, nxt_state;
   logic [4:0] divCnt_ff, nxt_divCnt;
   logic [3:0] bitCnt_ff, nxt_bitCnt;
   logic [1:0] trackCnt_ff, nxt_trackCnt;
   logic [6:0] burstLeft_ff, nxt_burstLeft;
   logic firstOfBurst_ff, nxt_firstOfBurst;
   logic [ACC_WIDTH-1:0] acc_ff, nxt_acc;
   logic done_ff, nxt_done;
   logic [7:0] rdData_ff, nxt_rdData;

   logic sourceTick;
   logic sarTick;
   logic convEnd;
   logic [3:0] convLen;
   logic [RES_WIDTH-1:0] convResult;
   logic [ACC_WIDTH-1:0] readout;

   // Repeat code to count minus one; reserved codes run one conversion
   function automatic logic [6:0] repeatLast(input logic [2:0] code);
      case (code)
         3'h1: repeatLast = 7'h03;
         3'h2: repeatLast = 7'h07;
         3'h3: repeatLast = 7'h0f;
         3'h4: repeatLast = 7'h1f;
         3'h5: repeatLast = 7'h3f;
         default: repeatLast = 7'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Conversion clock and result shaping
   // ----------------------------------------------------------------
   always_comb begin
      sourceTick = burstModeEnable ? lpOscTick : 1'b1;
      // divide by field plus one
      // At or above, so a smaller divider acts at once instead of waiting for a wrap
      sarTick = sourceTick && (divCnt_ff >= convCfg_ff.sarClockDivider);
      // two fewer cycles in 8-bit mode
      convLen = convCfg_ff.eightBitModeEnable ? BITS_EIGHT : BITS_TEN;
      convEnd = (state_ff == ST_CONVERT) && sarTick && (bitCnt_ff == convLen - 4'h1);
      // low bits cleared in 8-bit mode
      convResult = sampleCode;
      if (convCfg_ff.eightBitModeEnable) begin
         convResult[1:0] = 2'b00;
      end
      // shift and justify, reserved reads as no shift
      case (accCfg_ff.shiftJustifySelect)
         3'h1: readout = acc_ff >> 1;
         3'h2: readout = acc_ff >> 2;
         3'h3: readout = acc_ff >> 3;
         SJ_LEFT: readout = acc_ff << LEFT_SHIFT;
         default: readout = acc_ff;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_convCfg = convCfg_ff;
      nxt_accCfg = accCfg_ff;
      nxt_state = state_ff;
      nxt_divCnt = divCnt_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_trackCnt = trackCnt_ff;
      nxt_burstLeft = burstLeft_ff;
      nxt_firstOfBurst = firstOfBurst_ff;
      nxt_acc = acc_ff;
      nxt_done = 1'b0;
      nxt_rdData = rdData_ff;

      if (sourceTick) begin
         nxt_divCnt = sarTick ? 5'h00 : divCnt_ff + 5'h01;
      end

      // Register writes
      if (sfrWrEn) begin
         case (sfrAddr)
            CONV_CFG_ADDR: nxt_convCfg = sfrWrData;
            ACC_CFG_ADDR: nxt_accCfg = sfrWrData[6:0];
            // software loads the sum, zero restarts it
            RESULT_LOW_ADDR: nxt_acc[7:0] = sfrWrData;
            RESULT_HIGH_ADDR: nxt_acc[15:8] = sfrWrData;
            default: ;
         endcase
      end

      // Register reads, unmapped addresses return zero
      if (sfrRdEn) begin
         case (sfrAddr)
            CONV_CFG_ADDR: nxt_rdData = convCfg_ff;
            ACC_CFG_ADDR: nxt_rdData = {2'b00, accCfg_ff.shiftJustifySelect,
                                        accCfg_ff.repeatCount};
            // low byte reads zero in 8-bit mode
            RESULT_LOW_ADDR: nxt_rdData = convCfg_ff.eightBitModeEnable ? 8'h00 : readout[7:0];
            RESULT_HIGH_ADDR: nxt_rdData = readout[15:8];
            default: nxt_rdData = 8'h00;
         endcase
      end

      case (state_ff)
         ST_IDLE: begin
            // each start taken while idle and enabled launches one conversion or one burst
            if (startConversion && converterEnable) begin
               nxt_burstLeft = burstModeEnable ? repeatLast(accCfg_ff.repeatCount) : 7'h00;
               nxt_firstOfBurst = 1'b1;
               nxt_bitCnt = 4'h0;
               nxt_trackCnt = 2'h0;
               nxt_state = convCfg_ff.delayedTrackSelect ? ST_TRACK : ST_CONVERT;
            end
         end
         ST_TRACK: begin
            if (sarTick) begin
               if (trackCnt_ff == DELAYED_TRACK_CYCLES - 2'h1) begin
                  nxt_state = ST_CONVERT;
               end else begin
                  nxt_trackCnt = trackCnt_ff + 2'h1;
               end
            end
         end
         ST_CONVERT: begin
            if (sarTick) begin
               nxt_bitCnt = bitCnt_ff + 4'h1;
            end
            if (convEnd) begin
               nxt_firstOfBurst = 1'b0;
               nxt_bitCnt = 4'h0;
               nxt_trackCnt = 2'h0;
               // sum or latest result; conversion beats a result write
               if (burstModeEnable) begin
                  nxt_acc = firstOfBurst_ff ? ACC_WIDTH'(convResult)
                                            : acc_ff + ACC_WIDTH'(convResult);
               end else begin
                  nxt_acc = accCfg_ff.accumulateEnable ? acc_ff + ACC_WIDTH'(convResult)
                                                       : ACC_WIDTH'(convResult);
               end
               // done only after the last repeat
               if (burstModeEnable && burstLeft_ff != 7'h00) begin
                  nxt_burstLeft = burstLeft_ff - 7'h01;
                  nxt_state = convCfg_ff.delayedTrackSelect ? ST_TRACK : ST_CONVERT;
               end else begin
                  nxt_state = ST_IDLE;
                  nxt_done = 1'b1;
               end
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         convCfg_ff <= CONV_CFG_RESET;
         accCfg_ff <= ACC_CFG_RESET[6:0];
         state_ff <= ST_IDLE;
         divCnt_ff <= 5'h00;
         bitCnt_ff <= 4'h0;
         trackCnt_ff <= 2'h0;
         burstLeft_ff <= 7'h00;
         firstOfBurst_ff <= 1'b0;
         acc_ff <= 16'h0000;
         done_ff <= 1'b0;
         rdData_ff <= 8'h00;
      end else begin
         convCfg_ff <= nxt_convCfg;
         accCfg_ff <= nxt_accCfg;
         state_ff <= nxt_state;
         divCnt_ff <= nxt_divCnt;
         bitCnt_ff <= nxt_bitCnt;
         trackCnt_ff <= nxt_trackCnt;
         burstLeft_ff <= nxt_burstLeft;
         firstOfBurst_ff <= nxt_firstOfBurst;
         acc_ff <= nxt_acc;
         done_ff <= nxt_done;
         rdData_ff <= nxt_rdData;
      end
   end

   assign sfrRdData = rdData_ff;
   assign conversionClock = sarTick;
   assign trackActive = (state_ff == ST_TRACK);
   assign converting = (state_ff == ST_CONVERT);
   // gain select straight from the register
   assign inputGainUnity = convCfg_ff.inputGainSelect;
   // window compare deferred to the same point
   assign conversionDone = done_ff;
   assign windowCompareGo = done_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_DIV_ONE: assert property (@(posedge clock) disable iff (sys_rst)
      sarTick && !burstModeEnable && convCfg_ff.sarClockDivider == 5'h00 && !sfrWrEn
      |=> sarTick)
      else $error("divide by one did not tick every cycle");
   AST_BURST_SRC: assert property (@(posedge clock) disable iff (sys_rst)
      burstModeEnable && !lpOscTick |-> !sarTick)
      else $error("conversion clock ticked without oscillator tick in burst");
   AST_EIGHT_LOW: assert property (@(posedge clock) disable iff (sys_rst)
      sfrRdEn && sfrAddr == RESULT_LOW_ADDR && convCfg_ff.eightBitModeEnable
      |=> sfrRdData == 8'h00)
      else $error("low byte not zero in eight bit mode");
   AST_NORMAL_TRACK: assert property (@(posedge clock) disable iff (sys_rst)
      state_ff == ST_IDLE && startConversion && converterEnable
      && !convCfg_ff.delayedTrackSelect |=> state_ff == ST_CONVERT)
      else $error("normal track did not convert at once");
   AST_DELAY_TRACK: assert property (@(posedge clock) disable iff (sys_rst)
      state_ff == ST_TRACK && trackCnt_ff != 2'h2 |=> state_ff != ST_CONVERT)
      else $error("conversion began before three tracking clocks");
   AST_LATEST: assert property (@(posedge clock) disable iff (sys_rst)
      convEnd && !burstModeEnable && !accCfg_ff.accumulateEnable
      |=> acc_ff == ACC_WIDTH'($past(convResult)))
      else $error("latest result not stored");
   AST_AE_READ: assert property (@(posedge clock) disable iff (sys_rst)
      sfrRdEn && sfrAddr == ACC_CFG_ADDR |=> sfrRdData[7:6] == 2'b00)
      else $error("accumulate bit read back non-zero");
   AST_HIGH_RAW: assert property (@(posedge clock) disable iff (sys_rst)
      sfrRdEn && sfrAddr == RESULT_HIGH_ADDR && accCfg_ff.shiftJustifySelect == 3'h0
      |=> sfrRdData == $past(acc_ff[15:8]))
      else $error("unshifted high byte mismatch");
   AST_DONE_LAST: assert property (@(posedge clock) disable iff (sys_rst)
      convEnd && burstModeEnable && burstLeft_ff != 7'h00 |=> !conversionDone)
      else $error("completion flagged before the last repeat");

endmodule // adcca_config_accumulator

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import adcca_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, converterEnable = 1'b1;
   logic burstModeEnable = 1'b0, startConversion = 1'b0, lpOscTick = 1'b0;
   logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
   logic [9:0] sampleCode = 10'h000;
   logic conversionClock, trackActive, converting, inputGainUnity;
   logic conversionDone, windowCompareGo;
   int mismatches = 0, n_checks = 0, doneCount = 0, cyc = 0, lastTick = 0, tickGap = 0;
   int trackCycles = 0, convCycles = 0, t0 = 0, n = 0, d0 = 0;

   adcca_config_accumulator adcca_config_accumulator_inst (
      .clock(clock), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
      .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
      .converterEnable(converterEnable), .burstModeEnable(burstModeEnable),
      .startConversion(startConversion), .lpOscTick(lpOscTick), .sampleCode(sampleCode),
      .conversionClock(conversionClock), .trackActive(trackActive), .converting(converting),
      .inputGainUnity(inputGainUnity), .conversionDone(conversionDone),
      .windowCompareGo(windowCompareGo));

   initial begin
      forever #2.5 clock = ~clock;
   end

   // Oscillator ticks every other cycle so its divider period differs from the system one
   always @(posedge clock) lpOscTick <= #1 burstModeEnable & ~lpOscTick;

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (conversionClock === 1'b1) begin
         tickGap <= cyc - lastTick;
         lastTick <= cyc;
      end
      if (trackActive === 1'b1) trackCycles <= trackCycles + 1;
      if (converting === 1'b1) convCycles <= convCycles + 1;
      if (conversionDone === 1'b1) begin
         doneCount <= doneCount + 1;
         chk("windowGo", {15'h0000, windowCompareGo}, 16'h0001);
      end
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 sfrWrEn = 1'b1;
      sfrAddr = a;
      sfrWrData = d;
      @(posedge clock);
      #1 sfrWrEn = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1 sfrRdEn = 1'b1;
      sfrAddr = a;
      @(posedge clock);
      #1 sfrRdEn = 1'b0;
      d = sfrRdData;
   endtask

   task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
   endtask

   task automatic chkRes(input logic [15:0] exp);
      logic [7:0] hi;
      logic [7:0] lo;
      rd(RESULT_HIGH_ADDR, hi);
      rd(RESULT_LOW_ADDR, lo);
      chk("result", {hi, lo}, exp);
   endtask

   task automatic pulse();
      @(posedge clock);
      #1 startConversion = 1'b1;
      @(posedge clock);
      #1 startConversion = 1'b0;
   endtask

   // Counts edges after the start is taken until the done pulse shows
   task automatic conv(input logic [9:0] code);
      sampleCode = code;
      pulse();
      n = 0;
      while (conversionDone !== 1'b1 && n < 3000) begin
         @(posedge clock);
         #1 n++;
      end
      if (n >= 3000) begin
         mismatches++;
         $display("unexpected done: expected pulse seen none");
         test_done();
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      #1 sys_rst = 1'b0;
      chkReg(CONV_CFG_ADDR, CONV_CFG_RESET);
      chkReg(ACC_CFG_ADDR, ACC_CFG_RESET);
      chkReg(8'h00, 8'h00);
      chk("gain", {15'h0000, inputGainUnity}, 16'h0000);
      $display("test reset values done");
      wr(CONV_CFG_ADDR, 8'h19);
      chk("gain", {15'h0000, inputGainUnity}, 16'h0001);
      chkReg(CONV_CFG_ADDR, 8'h19);
      conv(10'h2a5);
      chk("tickGap", 16'(tickGap), 16'h0004);
      chkRes(16'h02a5);
      wr(CONV_CFG_ADDR, 8'h01);
      conv(10'h2a5);
      chk("normalTrackLen", 16'(n), 16'h000a);
      for (int s = 1; s < 4; s++) begin
         wr(ACC_CFG_ADDR, 8'(s * 8));
         chkRes(16'h02a5 >> s);
      end
      wr(ACC_CFG_ADDR, 8'h20);
      chkRes(16'ha940);
      wr(ACC_CFG_ADDR, 8'h38);
      chkReg(ACC_CFG_ADDR, 8'h38);
      chkRes(16'h02a5);
      $display("test format done");
      wr(ACC_CFG_ADDR, 8'h40);
      chkReg(ACC_CFG_ADDR, 8'h00);
      wr(RESULT_HIGH_ADDR, 8'h00);
      wr(RESULT_LOW_ADDR, 8'h00);
      chkRes(16'h0000);
      conv(10'h3ff);
      conv(10'h3ff);
      chkRes(16'h07fe);
      wr(RESULT_HIGH_ADDR, 8'h00);
      wr(RESULT_LOW_ADDR, 8'h00);
      conv(10'h3ff);
      chkRes(16'h03ff);
      $display("test accumulate done");
      wr(ACC_CFG_ADDR, 8'h00);
      wr(CONV_CFG_ADDR, 8'h03);
      t0 = trackCycles;
      conv(10'h2a7);
      chk("delayedTrackLen", 16'(n), 16'h000d);
      chk("trackCycles", 16'(trackCycles - t0), 16'h0003);
      chkRes(16'h02a7);
      wr(CONV_CFG_ADDR, 8'h05);
      t0 = convCycles;
      conv(10'h2a7);
      chk("eightBitLen", 16'(n), 16'h0008);
      chk("eightBitConv", 16'(convCycles - t0), 16'h0008);
      chkRes(16'h0200);
      converterEnable = 1'b0;
      d0 = doneCount;
      t0 = convCycles;
      pulse();
      repeat (40) @(posedge clock);
      chk("disabledDones", 16'(doneCount - d0), 16'h0000);
      chk("disabledConv", 16'(convCycles - t0), 16'h0000);
      #1 converterEnable = 1'b1;
      $display("test modes done");
      wr(CONV_CFG_ADDR, 8'h01);
      burstModeEnable = 1'b1;
      for (int c = 0; c < 6; c++) begin
         wr(ACC_CFG_ADDR, 8'(c));
         d0 = doneCount;
         conv(10'h3ff);
         chkRes(16'(((c == 0) ? 1 : (2 << c)) * 1023));
         chk("burstDones", 16'(doneCount - d0), 16'h0001);
      end
      chk("tickGap", 16'(tickGap), 16'h0002);
      wr(ACC_CFG_ADDR, 8'h07);
      conv(10'h3ff);
      chkRes(16'h03ff);
      wr(ACC_CFG_ADDR, 8'h00);
      burstModeEnable = 1'b0;
      $display("test burst done");
      test_done();
   end
endmodule // tb_top
